// ===== pkg/jitter_elastic_store_params.svh
// Offsets, reset values and timing counts of the jitter elastic store.
`ifndef JITTER_ELASTIC_STORE_PARAMS_SVH
`define JITTER_ELASTIC_STORE_PARAMS_SVH
`define WR_PTR_INIT 4'h0
`define RD_PTR_INIT 4'hB
`define FILL_CENTRE 4'h4
`define FILL_OVER 4'h9
`define RELOCK_GAP 4'h4
`define LOAD_INIT 8'h80
`define LOAD_MAX 8'hFF
`define NCO_INC_MAX 16'h0A80
`define CLK_PERIOD_NS 5
`define POWERUP_TIME_NS 3000000
`define POWERUP_CYCLES (`POWERUP_TIME_NS / `CLK_PERIOD_NS)
`define NOCLK_TIME_NS 1000
`define NOCLK_CYCLES (`NOCLK_TIME_NS / `CLK_PERIOD_NS)
`define TRIM_PERIOD 10'h3FF
`endif

// ===== pkg/jitter_elastic_store_pkg.sv
// Types shared by the jitter elastic store.
package jitter_elastic_store_pkg;
   typedef enum logic {
      ST_INIT = 1'b0,
      ST_RUN  = 1'b1
   } init_state_type;
   typedef struct packed {
      logic [3:0] fill;
      logic       under;
      logic       over;
   } fifo_view_type;
endpackage

// ===== hdl/jitter_elastic_store.sv
// Jitter elastic store: eight-bit FIFO, steered read clock, slip flag.
`timescale 1ns/1ps
`default_nettype none
`include "jitter_elastic_store_params.svh"
// Behaviour
// RL1: Low flag_clear_n clears slip_flag.
// RL2: Low pointer_init_n reinitialises both pointers; held data may be lost.
// RL3: alt_read_select at 0 advances the read pointer from the steered oscillator.
// RL4: alt_read_select at 1 advances the read pointer from alt_read_clock.
// RL5: In alternate mode out_bit_clock follows alt_read_clock in frequency and phase.
// RL6: din is sampled on each in_bit_clock falling edge at the write pointer.
// RL7: dout is stable and valid at each rising edge of out_bit_clock.
// RL8: out_bit_clock is a clean registered clock aligned with dout.
// RL9: slip_flag sets on overflow or underflow and stays until cleared.
// RL10: Read pointer overtaking the write pointer is an error.
// RL11: Internal logic sets the oscillator load code, steering read frequency.
// RL12: Without input clock the load code is driven to one end of range.
// RL13: At least three unit intervals of jitter are absorbed without error.
// RL14: With centred oscillator, pointers sit at optimum and seven intervals are absorbed.
// RL15: The source must keep alt_read_clock at the input average frequency.
// RL16: Pointer reset puts write at first and read at fourth location.
// RL17: The load code is updated periodically to hold the FIFO half full.
// RL18: On slip the buffered bits are lost and the store relocks immediately.
// RL19: After power-up slip_flag stays high about 3 ms, then falls.
// RL20: Eight one-bit entries, pointers wrap modulo sixteen in their own domains and address by their low three bits.
// RL21: The write pointer crosses into the system clock as a synchronised Gray copy.
module jitter_elastic_store #(
   parameter int POWERUP_CYCLES = `POWERUP_CYCLES
) (
   // System clock and reset.
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Serial input link.
   input  wire logic       in_bit_clock,
   input  wire logic       din,
   // Alternate read clock.
   input  wire logic       alt_read_clock,
   input  wire logic       alt_read_select,
   // Control pins.
   input  wire logic       flag_clear_n,
   input  wire logic       pointer_init_n,
   // Serial output and status.
   output logic            dout,
   output logic            out_bit_clock,
   output logic            osc_buffer_out,
   output logic            slip_flag,
   output logic [7:0]      osc_load_code
);

   // ----------------------------------------
   // Helper functions.
   // ----------------------------------------
   function automatic logic [3:0] bin2gray(input logic [3:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   function automatic logic [3:0] gray2bin(input logic [3:0] g);
      gray2bin = {g[3], g[3] ^ g[2], g[3] ^ g[2] ^ g[1], g[3] ^ g[2] ^ g[1] ^ g[0]};
   endfunction

   // ----------------------------------------
   // Write domain on the input bit clock.
   // ----------------------------------------
   logic       wr_rst_n;
   logic [7:0] mem_reg;
   logic [3:0] wr_ptr_reg;
   logic [3:0] wr_gray_reg;
   logic [3:0] wr_ptr_next;

   assign wr_rst_n = reset_n & pointer_init_n;
   assign wr_ptr_next = wr_ptr_reg + 4'h1;

   always_ff @(negedge in_bit_clock or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wr_ptr_reg  <= `WR_PTR_INIT; // [RL2] [RL16]
         wr_gray_reg <= `WR_PTR_INIT;
      end else begin
         wr_ptr_reg  <= wr_ptr_next; // [RL20]
         wr_gray_reg <= bin2gray(wr_ptr_next); // [RL21]
      end
   end

   always_ff @(negedge in_bit_clock or negedge reset_n) begin
      if (!reset_n) begin
         mem_reg <= 8'h00;
      end else begin
         mem_reg[wr_ptr_reg[2:0]] <= din; // [RL6]
      end
   end

   // ----------------------------------------
   // Synchronisers into the system clock.
   // ----------------------------------------
   logic [3:0] wr_g1_reg;
   logic [3:0] wr_g2_reg;
   logic [4:0] pin1_reg;
   logic [4:0] pin2_reg;
   logic       alt_prev_reg;
   logic       sel_s;
   logic       clr_s;
   logic       ptr_s;
   logic       alt_s;
   logic [3:0] wr_sync;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_g1_reg    <= 4'h0;
         wr_g2_reg    <= 4'h0;
         pin1_reg     <= 5'h00;
         pin2_reg     <= 5'h00;
         alt_prev_reg <= 1'b0;
      end else begin
         wr_g1_reg    <= wr_gray_reg;
         wr_g2_reg    <= wr_g1_reg; // [RL21]
         pin1_reg     <= {alt_read_clock, alt_read_select, flag_clear_n, pointer_init_n, 1'b0};
         pin2_reg     <= pin1_reg;
         alt_prev_reg <= pin2_reg[4];
      end
   end

   assign alt_s   = pin2_reg[4];
   assign sel_s   = pin2_reg[3];
   assign clr_s   = pin2_reg[2];
   assign ptr_s   = pin2_reg[1];
   assign wr_sync = gray2bin(wr_g2_reg);

   // ----------------------------------------
   // Steered oscillator.
   // ----------------------------------------
   logic [15:0] nco_reg;
   logic        nco_prev_reg;
   logic [7:0]  load_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nco_reg      <= 16'h0000;
         nco_prev_reg <= 1'b0;
      end else begin
         nco_reg      <= nco_reg + `NCO_INC_MAX - {8'h00, load_reg}; // [RL11]
         nco_prev_reg <= nco_reg[15];
      end
   end

   assign osc_buffer_out = nco_reg[15];

   // ----------------------------------------
   // Read side and output clock.
   // ----------------------------------------
   jitter_elastic_store_pkg::init_state_type state_reg;
   jitter_elastic_store_pkg::fifo_view_type  view;
   logic [3:0] rd_ptr_reg;
   logic       src_level;
   logic       src_fall;
   logic       slip_event;

   assign src_level = sel_s ? alt_s : nco_reg[15]; // [RL3] [RL4]
   assign src_fall  = sel_s ? (alt_prev_reg & ~alt_s) : (nco_prev_reg & ~nco_reg[15]);
   assign view.fill  = wr_sync - rd_ptr_reg;
   assign view.under = src_fall & (view.fill == 4'h0); // [RL10]
   assign view.over  = view.fill >= `FILL_OVER; // [RL13] [RL14]
   assign slip_event = ptr_s & (view.under | view.over);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_bit_clock <= 1'b0;
      end else begin
         out_bit_clock <= src_level; // [RL5] [RL8]
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ptr_reg <= `RD_PTR_INIT;
         dout       <= 1'b0;
      end else if (!ptr_s) begin
         rd_ptr_reg <= `RD_PTR_INIT; // [RL2] [RL16]
      end else if (slip_event) begin
         rd_ptr_reg <= wr_sync - `RELOCK_GAP; // [RL18]
      end else if (src_fall) begin
         rd_ptr_reg <= rd_ptr_reg + 4'h1; // [RL20]
         dout       <= mem_reg[rd_ptr_reg[2:0]]; // [RL7]
      end
   end

   // ----------------------------------------
   // Power-up sequence and slip flag.
   // ----------------------------------------
   logic [19:0] init_cnt_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg    <= jitter_elastic_store_pkg::ST_INIT;
         init_cnt_reg <= 20'h00000;
      end else begin
         unique case (state_reg)
            jitter_elastic_store_pkg::ST_INIT: begin
               init_cnt_reg <= init_cnt_reg + 20'h00001;
               if (init_cnt_reg == 20'(POWERUP_CYCLES - 1)) begin
                  state_reg <= jitter_elastic_store_pkg::ST_RUN; // [RL19]
               end
            end
            jitter_elastic_store_pkg::ST_RUN: begin
               state_reg <= jitter_elastic_store_pkg::ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         slip_flag <= 1'b1;
      end else if (state_reg == jitter_elastic_store_pkg::ST_INIT) begin
         slip_flag <= (init_cnt_reg != 20'(POWERUP_CYCLES - 1)); // [RL19]
      end else if (!clr_s) begin
         slip_flag <= 1'b0; // [RL1]
      end else if (slip_event) begin
         slip_flag <= 1'b1; // [RL9]
      end
   end

   // ----------------------------------------
   // Load control loop.
   // ----------------------------------------
   logic [9:0] trim_cnt_reg;
   logic [7:0] idle_cnt_reg;
   logic [3:0] wr_last_reg;
   logic       trim_tick;
   logic       clock_lost;

   assign trim_tick  = trim_cnt_reg == `TRIM_PERIOD;
   assign clock_lost = idle_cnt_reg == 8'(`NOCLK_CYCLES);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trim_cnt_reg <= 10'h000;
         idle_cnt_reg <= 8'h00;
         wr_last_reg  <= 4'h0;
      end else begin
         trim_cnt_reg <= trim_cnt_reg + 10'h001;
         wr_last_reg  <= wr_sync;
         if (wr_sync != wr_last_reg) begin
            idle_cnt_reg <= 8'h00;
         end else if (!clock_lost) begin
            idle_cnt_reg <= idle_cnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         load_reg <= `LOAD_INIT;
      end else if (trim_tick) begin
         if (clock_lost) begin
            if (load_reg != `LOAD_MAX) begin
               load_reg <= load_reg + 8'h01; // [RL12]
            end
         end else if (view.fill > `FILL_CENTRE && load_reg != 8'h00) begin
            load_reg <= load_reg - 8'h01; // [RL17]
         end else if (view.fill < `FILL_CENTRE && load_reg != `LOAD_MAX) begin
            load_reg <= load_reg + 8'h01; // [RL17]
         end
      end
   end

   assign osc_load_code = load_reg;

   // ----------------------------------------
   // Assertions.
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic run;
   assign run = state_reg == jitter_elastic_store_pkg::ST_RUN;

   sequence s_clear_held;
      run && !clr_s;
   endsequence
   property p_flag_clear;
      s_clear_held |=> !slip_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [RL1]

   property p_ptr_init;
      !ptr_s |=> rd_ptr_reg == `RD_PTR_INIT;
   endproperty
   a_ptr_init: assert property (p_ptr_init) else $error("read pointer not reset"); // [RL2]

   property p_read_advance;
      src_fall && ptr_s && !slip_event |=> rd_ptr_reg == $past(rd_ptr_reg) + 4'h1;
   endproperty
   a_read_advance: assert property (p_read_advance) else $error("read pointer stuck"); // [RL3]

   property p_alt_follow;
      sel_s |=> out_bit_clock == $past(alt_s);
   endproperty
   a_alt_follow: assert property (p_alt_follow) else $error("out clock lost alt"); // [RL5]

   property p_dout_stable;
      $rose(out_bit_clock) |-> $stable(dout);
   endproperty
   a_dout_stable: assert property (p_dout_stable) else $error("dout moved at rise"); // [RL7]

   property p_slip_set;
      run && clr_s && slip_event |=> slip_flag;
   endproperty
   a_slip_set: assert property (p_slip_set) else $error("slip not flagged"); // [RL9]

   property p_underflow;
      ptr_s && src_fall && view.fill == 4'h0 |-> slip_event;
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow missed"); // [RL10]

   property p_powerup;
      state_reg == jitter_elastic_store_pkg::ST_INIT |-> slip_flag;
   endproperty
   a_powerup: assert property (p_powerup) else $error("flag low during init"); // [RL19]
   property p_ready;
      $rose(run) |-> !slip_flag;
   endproperty
   a_ready: assert property (p_ready) else $error("flag high after init"); // [RL19]

   property p_noclk;
      clock_lost && trim_tick && load_reg != `LOAD_MAX |=> load_reg == $past(load_reg) + 8'h01;
   endproperty
   a_noclk: assert property (p_noclk) else $error("load not driven to end"); // [RL12]

   property p_wr_step;
      @(negedge in_bit_clock) disable iff (!wr_rst_n)
         1 |=> wr_ptr_reg == $past(wr_ptr_reg) + 4'h1;
   endproperty
   a_wr_step: assert property (p_wr_step) else $error("write pointer stuck"); // [RL6]

endmodule
`default_nettype wire

// ===== testbench/jes_link_partner.sv
// Link source and alternate read clock model facing the elastic store.
`timescale 1ns/1ps
`default_nettype none
module jes_link_partner (
   // Control from the bench.
   input  wire logic frame_en,
   input  wire logic next_bit,
   // Link and read clock toward the store.
   output logic      in_bit_clock,
   output logic      din,
   output logic      alt_read_clock
);
   // ----
   // Link clock stands high between frames while data keeps moving.
   // ----
   initial begin
      in_bit_clock = 1'b1;
      din = 1'b0;
      #1.3;
      forever begin
         if (frame_en) begin
            in_bit_clock = 1'b0;
            #40 in_bit_clock = 1'b1;
            #10 din = next_bit;   // Held 50 ns past the fall, set up 30 ns before.
            #30;
         end else begin
            #80 din = ~din;
         end
      end
   end
   // ----
   // Read clock at the same 80 ns period as the link clock.
   // ----
   initial begin
      alt_read_clock = 1'b0;
      #33.7;
      forever begin
         #40;
         if (frame_en) alt_read_clock = ~alt_read_clock;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/jitter_elastic_store_bench.sv
// Self-checking bench of the jitter elastic store.
`timescale 1ns/1ps
`default_nettype none
module jitter_elastic_store_bench;
   // ----
   // Signals
   // ----
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       alt_read_select = 1'b1;
   logic       flag_clear_n = 1'b1;
   logic       pointer_init_n = 1'b0;
   logic       frame_en = 1'b0;
   logic       next_bit = 1'b0;
   logic       in_bit_clock;
   logic       din;
   logic       alt_read_clock;
   logic       dout;
   logic       out_bit_clock;
   logic       osc_buffer_out;
   logic       slip_flag;
   logic [7:0] osc_load_code;
   logic [2:0] alt_hist = 3'h0;
   logic       follow_on = 1'b0;
   logic       rec_on = 1'b0;
   int         err_total = 0;
   int         compares = 0;
   int         cycles = 0;
   int         obc_rises = 0;
   int         osc_rises = 0;
   logic       wq[$];
   logic       rq[$];

   always #2.5 clk = ~clk;

   jitter_elastic_store #(.POWERUP_CYCLES(50)) u_jitter_elastic_store (
      .clk(clk), .reset_n(reset_n), .in_bit_clock(in_bit_clock), .din(din),
      .alt_read_clock(alt_read_clock), .alt_read_select(alt_read_select),
      .flag_clear_n(flag_clear_n), .pointer_init_n(pointer_init_n), .dout(dout),
      .out_bit_clock(out_bit_clock), .osc_buffer_out(osc_buffer_out),
      .slip_flag(slip_flag), .osc_load_code(osc_load_code));

   jes_link_partner u_jes_link_partner (
      .frame_en(frame_en), .next_bit(next_bit), .in_bit_clock(in_bit_clock),
      .din(din), .alt_read_clock(alt_read_clock));

   // ----
   // Reference model: written and read bit streams
   // ----
   always @(negedge in_bit_clock) if (rec_on) wq.push_back(din);
   always @(posedge out_bit_clock) if (rec_on) rq.push_back(dout);
   always @(posedge out_bit_clock) obc_rises++;
   always @(posedge osc_buffer_out) osc_rises++;
   always @(posedge clk) alt_hist <= {alt_hist[1:0], alt_read_clock};
   always @(negedge clk) next_bit <= 1'($urandom);

   task automatic chk1(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("Counts: compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Output clock tracks the read clock three samples late; also run-time ceiling.
   always @(negedge clk) begin
      cycles++;
      if (follow_on) chk1("out_bit_clock follow", alt_hist[2], out_bit_clock);
      if (cycles > 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ----
   // Tests
   // ----
   task automatic run_stream(input string name);
      int   k;
      int   i;
      logic found;
      @(negedge clk);
      alt_read_select = 1'b1;
      frame_en = 1'b1;
      pointer_init_n = 1'b0;
      repeat (10) @(negedge clk);
      follow_on = 1'b1;
      repeat (20) @(negedge clk);
      wq.delete();
      rq.delete();
      flag_clear_n = 1'b0;
      pointer_init_n = 1'b1;
      rec_on = 1'b1;
      repeat (8) @(negedge clk);
      flag_clear_n = 1'b1;
      repeat (1400) @(negedge clk);
      rec_on = 1'b0;
      follow_on = 1'b0;
      chk1({name, " slip_flag"}, 1'b0, slip_flag);
      found = 1'b0;
      for (k = 3; k <= 7; k++) begin
         if (!found && rq.size() >= k + 48 && wq.size() >= 48) begin
            found = 1'b1;
            for (i = 0; i < 48; i++) begin
               if (rq[k + i] !== wq[i]) found = 1'b0;
            end
         end
      end
      chk1({name, " bit order"}, 1'b1, found);
      $display("Test %s done", name);
   endtask

   task automatic run_osc();
      logic [7:0] base;
      int         gap;
      @(negedge clk);
      alt_read_select = 1'b0;
      repeat (400) @(negedge clk);
      chk1("slip_flag overflow", 1'b1, slip_flag);
      flag_clear_n = 1'b0;
      repeat (6) @(negedge clk);
      chk1("slip_flag overflow clear", 1'b0, slip_flag);
      flag_clear_n = 1'b1;
      frame_en = 1'b0;
      repeat (300) @(negedge clk);
      chk1("slip_flag underflow", 1'b1, slip_flag);
      obc_rises = 0;
      osc_rises = 0;
      base = osc_load_code;
      repeat (6000) @(negedge clk);
      gap = obc_rises - osc_rises;
      chk1("oscillator read pace", 1'b1, osc_rises > 100 && gap >= -1 && gap <= 1);
      chk1("load code ramp", 1'b1,
           osc_load_code >= ((base > 8'hFB) ? 8'hFF : base + 8'h04));
      flag_clear_n = 1'b0;
      repeat (6) @(negedge clk);
      chk1("slip_flag clear", 1'b0, slip_flag);
      flag_clear_n = 1'b1;
      repeat (300) @(negedge clk);
      chk1("slip_flag sticky", 1'b1, slip_flag);
      $display("Test oscillator done");
   endtask

   initial begin
      void'($urandom(28319));
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      repeat (10) @(negedge clk);
      chk1("slip_flag power-up", 1'b1, slip_flag);
      repeat (50) @(negedge clk);
      chk1("slip_flag ready", 1'b0, slip_flag);
      $display("Test power-up done");
      run_stream("first lock");
      run_osc();
      run_stream("relock");
      tally_and_finish();
   end
endmodule
`default_nettype wire
